//--- common/ctl_if.sv
// Control bits between the register slave and the transfer engine
// Assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface ctl_if;
	logic [31:0] en;
	logic [31:0] burst_only;
	logic [31:0] hw_dis;
	logic [21:0] tbl_base;
	logic busy;
	logic [4:0] cur_chan;
	modport regs (output en, burst_only, tbl_base, input hw_dis, busy, cur_chan);
	modport eng (input en, burst_only, tbl_base, output hw_dis, busy, cur_chan);
endinterface : ctl_if
`default_nettype wire

//--- common/dma_defs.svh
// Constants of the DMA request and channel control block
// Assumes inclusion by its bare name from every file that decodes them
// ==========================================================================
// Summary of operation
// R1 - A single request without a burst request moves one item, then waits.
// R2 - A burst request moves the lesser of arbitration size and items left.
// R3 - Software sets arbitration size to what the peripheral burst can take.
// R4 - A channel marked burst-only ignores single requests, serves bursts alone.
// R5 - Software aligns the control table base on a 1024-byte boundary.
// R6 - Primary structures at 0x10 per channel; alternates start at 0x200.
// R7 - Structure holds source end, destination end, control word; ends inclusive.
// R8 - Software points a fixed end pointer at the fixed transfer address.
// R9 - Control word carries sizes, increments, arbitration, count, burst flag, mode.
// R10 - Count and mode are written back; at completion count 0, mode stop.
// R11 - End pointers are never written by the controller.
// R12 - Software rewrites the control word before each new transfer.
// R13 - Enable-set and enable-clear writes are honoured by the controller.
// R14 - A finished transfer clears the channel enable without software; in ping-pong mode the code leaves the enable set.
// R15 - Stop mode moves nothing and clears the channel enable.
// R16 - Basic mode continues only while items remain and request stays.
// R17 - Auto mode runs to completion once any request was seen.
// R18 - Ping-pong completion of one structure continues with the other.
// R19 - Every ping-pong switch raises the channel event.
// R20 - Ping-pong alternates indefinitely while both structures are valid.
// R21 - With both requests and burst setup, the burst request is served.
// R22 - Arbitration size is one to 1024 items, then channels are rearbitrated.
// R23 - Among requesting channels the lowest number wins.
// R24 - Disabled channels are ignored and their structures left untouched.
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH
// ==========================================================================
// Control table layout
`define NCH 32
`define TBL_LSB 10
`define ALT_OFS 32'h0000_0200
`define SRC_END_OFS 32'h0000_0000
`define DST_END_OFS 32'h0000_0004
`define CTL_OFS 32'h0000_0008
// ==========================================================================
// Control word fields
`define CW_MODE 2:0
`define CW_BURST 3
`define CW_CNT 13:4
`define CW_ARB 17:14
`define CW_SSIZE 25:24
`define CW_SINC 27:26
`define CW_DSIZE 29:28
`define CW_DINC 31:30
`define ARB_MAX_LOG 4'ha
`define ARB_MAX 11'h400
`define MODE_STOP 3'h0
`define MODE_BASIC 3'h1
`define MODE_AUTO 3'h2
`define MODE_PINGPONG 3'h3
`define INC_NONE 2'h3
`define WORD_SIZE 2'h2
// ==========================================================================
// APB register offsets and reset values
`define REG_ENA_SET 12'h000
`define REG_ENA_CLR 12'h004
`define REG_BO_SET 12'h008
`define REG_BO_CLR 12'h00c
`define REG_TBL_BASE 12'h010
`define REG_STATUS 12'h014
`define EN_RST 32'h0000_0000
`define BO_RST 32'h0000_0000
`define BASE_RST 22'h00_0000
`endif

//--- common/dma_pkg.sv
// Types shared by the DMA channel control block
// Assumes nothing of its surroundings
`default_nettype none
package dma_pkg;
	// Engine sequence states
	typedef enum logic [2:0] {
		ST_ARB,
		ST_CTL,
		ST_SEP,
		ST_DEP,
		ST_RD,
		ST_WR,
		ST_WB
	} st_e;
endpackage : dma_pkg
`default_nettype wire

//--- rtl/dma_channel_ctrl.sv
// DMA request handling and channel control table sequencing, top level
// Assumes a memory port that answers each held request with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
`include "dma_defs.svh"
module dma_channel_ctrl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral requests
	input wire logic [`NCH-1:0] single_req,
	input wire logic [`NCH-1:0] burst_req,
	// System memory master
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	// Per-channel event pulses
	output logic [`NCH-1:0] chan_irq
);
	ctl_if c ();
	logic [`NCH-1:0] ss, sb;

	// ======================================================================
	// Sub-blocks
	dma_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.c(c)
	);

	dma_req_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.raw({burst_req, single_req}),
		.sync({sb, ss})
	);

	// ======================================================================
	// Helpers
	// Byte address of one word of a channel's primary or alternate structure
	function automatic logic [31:0] tbl_addr(input logic [21:0] base,
		input logic [4:0] ch, input logic alt, input logic [31:0] ofs);
		tbl_addr = {base, 10'h000} + (alt ? `ALT_OFS : 32'h0) + {23'h0, ch, 4'h0} + ofs; // R6
	endfunction : tbl_addr

	// Inclusive end pointer minus the span still to go; fixed if no increment
	function automatic logic [31:0] item_addr(input logic [31:0] endp,
		input logic [9:0] cnt, input logic [1:0] inc);
		item_addr = (inc == `INC_NONE) ? endp : endp - ({22'h0, cnt} << inc); // R7 R8
	endfunction : item_addr

	// Burst length: lesser of arbitration size and items left
	function automatic logic [10:0] blen(input logic [31:0] cw);
		logic [10:0] arb;
		logic [10:0] left;
		arb = (cw[`CW_ARB] > `ARB_MAX_LOG) ? `ARB_MAX : (11'h1 << cw[`CW_ARB]); // R22
		left = {1'b0, cw[`CW_CNT]} + 11'h1;
		blen = (arb < left) ? arb : left; // R2
	endfunction : blen

	// Lowest eligible channel, flag in the top bit
	function automatic logic [5:0] pick(input logic [`NCH-1:0] v);
		pick = 6'h0;
		for (int i = `NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				pick = {1'b1, 5'(i)}; // R23
			end
		end
	endfunction : pick

	// ======================================================================
	// Engine state
	dma_pkg::st_e st_q, st_d;
	logic [4:0] ch_q, ch_d;
	logic [`NCH-1:0] alt_q, alt_d, apend_q, apend_d;
	logic [`NCH-1:0] hwdis_q, hwdis_d, irq_q, irq_d;
	logic [31:0] cw_q, cw_d, sep_q, sep_d, dep_q, dep_d;
	logic [10:0] bl_q, bl_d;
	logic isb_q, isb_d, fin_q, fin_d;
	logic req_q, req_d, we_q, we_d;
	logic [31:0] addr_q, addr_d, wdata_q, wdata_d;
	logic [1:0] size_q, size_d;
	logic [`NCH-1:0] elig;
	logic [5:0] pk;
	logic [9:0] cnt;
	logic [2:0] mode;

	// Only enabled channels compete; pending auto work counts as a request
	assign elig = c.en & (sb | (ss & ~c.burst_only) | apend_q); // R4 R24 R17
	assign pk = pick(elig);
	assign cnt = cw_q[`CW_CNT];
	assign mode = cw_q[`CW_MODE];

	// Next-state logic of the transfer sequence
	always_comb begin
		st_d = st_q;
		ch_d = ch_q;
		alt_d = alt_q;
		apend_d = apend_q & c.en; // Stale auto work dies with the enable
		hwdis_d = '0;
		irq_d = '0;
		cw_d = cw_q;
		sep_d = sep_q;
		dep_d = dep_q;
		bl_d = bl_q;
		isb_d = isb_q;
		fin_d = fin_q;
		req_d = req_q & ~mem_ack;
		we_d = we_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		size_d = size_q;
		unique case (st_q)
		dma_pkg::ST_ARB: begin
			if (pk[5]) begin
				ch_d = pk[4:0];
				isb_d = sb[pk[4:0]] | apend_q[pk[4:0]]; // R21 R17
				req_d = 1'b1;
				we_d = 1'b0;
				size_d = `WORD_SIZE;
				addr_d = tbl_addr(c.tbl_base, pk[4:0], alt_q[pk[4:0]], `CTL_OFS);
				st_d = dma_pkg::ST_CTL;
			end
		end
		dma_pkg::ST_CTL: begin
			if (mem_ack) begin
				cw_d = mem_rdata; // R9
				if (mem_rdata[`CW_MODE] == `MODE_STOP || mem_rdata[`CW_MODE] > `MODE_PINGPONG) begin
					hwdis_d[ch_q] = 1'b1; // R15
					apend_d[ch_q] = 1'b0;
					st_d = dma_pkg::ST_ARB;
				end else if (mem_rdata[`CW_BURST] && !isb_q) begin
					st_d = dma_pkg::ST_ARB; // R4
				end else begin
					if (mem_rdata[`CW_MODE] == `MODE_AUTO) begin
						apend_d[ch_q] = 1'b1; // R17
					end
					bl_d = isb_q ? blen(mem_rdata) : 11'h1; // R1 R2
					req_d = 1'b1;
					addr_d = tbl_addr(c.tbl_base, ch_q, alt_q[ch_q], `SRC_END_OFS); // R7
					st_d = dma_pkg::ST_SEP;
				end
			end
		end
		dma_pkg::ST_SEP: begin
			if (mem_ack) begin
				sep_d = mem_rdata;
				req_d = 1'b1;
				addr_d = tbl_addr(c.tbl_base, ch_q, alt_q[ch_q], `DST_END_OFS); // R7
				st_d = dma_pkg::ST_DEP;
			end
		end
		dma_pkg::ST_DEP: begin
			if (mem_ack) begin
				dep_d = mem_rdata;
				req_d = 1'b1;
				size_d = cw_q[`CW_SSIZE];
				addr_d = item_addr(sep_q, cnt, cw_q[`CW_SINC]);
				st_d = dma_pkg::ST_RD;
			end
		end
		dma_pkg::ST_RD: begin
			if (mem_ack) begin
				wdata_d = mem_rdata;
				req_d = 1'b1;
				we_d = 1'b1;
				size_d = cw_q[`CW_DSIZE];
				addr_d = item_addr(dep_q, cnt, cw_q[`CW_DINC]);
				st_d = dma_pkg::ST_WR;
			end
		end
		dma_pkg::ST_WR: begin
			if (mem_ack) begin
				req_d = 1'b1;
				size_d = `WORD_SIZE;
				addr_d = tbl_addr(c.tbl_base, ch_q, alt_q[ch_q], `CTL_OFS); // R11
				st_d = dma_pkg::ST_WB;
				if (cnt == 10'h0) begin
					fin_d = 1'b1;
					wdata_d = cw_q;
					wdata_d[`CW_CNT] = 10'h0; // R10
					wdata_d[`CW_MODE] = `MODE_STOP; // R10
				end else begin
					fin_d = 1'b0;
					cw_d[`CW_CNT] = cnt - 10'h1;
					bl_d = bl_q - 11'h1;
					wdata_d = cw_d; // R10
					if (bl_q > 11'h1 && (mode == `MODE_AUTO || sb[ch_q])) begin // R16 R17 R2
						we_d = 1'b0;
						size_d = cw_q[`CW_SSIZE];
						addr_d = item_addr(sep_q, cnt - 10'h1, cw_q[`CW_SINC]);
						st_d = dma_pkg::ST_RD;
					end
				end
			end
		end
		dma_pkg::ST_WB: begin
			if (mem_ack) begin
				we_d = 1'b0;
				st_d = dma_pkg::ST_ARB; // R22
				if (fin_q) begin
					irq_d[ch_q] = 1'b1; // R19
					apend_d[ch_q] = 1'b0;
					if (mode == `MODE_PINGPONG) begin
						alt_d[ch_q] = ~alt_q[ch_q]; // R18 R20
					end else begin
						hwdis_d[ch_q] = 1'b1; // R14
					end
				end
			end
		end
		endcase
	end

	// Register stage of the engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= dma_pkg::ST_ARB;
			ch_q <= 5'h00;
			alt_q <= '0;
			apend_q <= '0;
			hwdis_q <= '0;
			irq_q <= '0;
			cw_q <= 32'h0;
			sep_q <= 32'h0;
			dep_q <= 32'h0;
			bl_q <= 11'h000;
			isb_q <= 1'b0;
			fin_q <= 1'b0;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 32'h0;
			wdata_q <= 32'h0;
			size_q <= 2'h0;
		end else begin
			st_q <= st_d;
			ch_q <= ch_d;
			alt_q <= alt_d;
			apend_q <= apend_d;
			hwdis_q <= hwdis_d;
			irq_q <= irq_d;
			cw_q <= cw_d;
			sep_q <= sep_d;
			dep_q <= dep_d;
			bl_q <= bl_d;
			isb_q <= isb_d;
			fin_q <= fin_d;
			req_q <= req_d;
			we_q <= we_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			size_q <= size_d;
		end
	end

	// Outputs and engine status toward the registers
	assign mem_req = req_q;
	assign mem_we = we_q;
	assign mem_addr = addr_q;
	assign mem_size = size_q;
	assign mem_wdata = wdata_q;
	assign chan_irq = irq_q;
	assign c.hw_dis = hwdis_q;
	assign c.busy = (st_q != dma_pkg::ST_ARB);
	assign c.cur_chan = ch_q;

	// ======================================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_item_done;
		st_q == dma_pkg::ST_WR && mem_ack;
	endsequence
	sequence s_fin_wb;
		st_q == dma_pkg::ST_WB && fin_q && mem_ack;
	endsequence

	AST_STOP_DIS: assert property (st_q == dma_pkg::ST_CTL && mem_ack // R15
		&& mem_rdata[`CW_MODE] == `MODE_STOP |=> hwdis_q[$past(ch_q)] && st_q == dma_pkg::ST_ARB)
		else $error("stop mode did not disable channel");
	AST_ONE_ITEM: assert property (s_item_done ##0 (cnt != 10'h0 && bl_q == 11'h1) // R1
		|=> st_q == dma_pkg::ST_WB && !fin_q)
		else $error("single request moved more than one item");
	AST_BURST_LEN: assert property (st_q == dma_pkg::ST_CTL && mem_ack && isb_q // R2
		&& mem_rdata[`CW_MODE] == `MODE_BASIC && !(mem_rdata[`CW_BURST] && !isb_q)
		|=> bl_q == blen($past(mem_rdata)))
		else $error("burst length not lesser of arbitration size and items left");
	AST_LOW_WINS: assert property (st_q == dma_pkg::ST_ARB && pk[5] // R23
		|-> (elig & ((32'h1 << pk[4:0]) - 32'h1)) == 32'h0 && c.en[pk[4:0]])
		else $error("granted channel is not the lowest eligible");
	AST_AUTO_RUN: assert property (s_item_done ##0 (mode == `MODE_AUTO && bl_q > 11'h1 // R17
		&& cnt != 10'h0) |=> st_q == dma_pkg::ST_RD)
		else $error("auto mode stopped inside a burst");
	AST_BASIC_HALT: assert property (s_item_done ##0 (mode == `MODE_BASIC && !sb[ch_q]) // R16
		|=> st_q == dma_pkg::ST_WB)
		else $error("basic mode continued without request");
	AST_DONE_WORD: assert property (st_q == dma_pkg::ST_WB && fin_q // R10
		|-> wdata_q[`CW_CNT] == 10'h0 && wdata_q[`CW_MODE] == `MODE_STOP)
		else $error("completion write-back not count 0 and stop");
	AST_PTR_KEEP: assert property (req_q && we_q && st_q == dma_pkg::ST_WB // R11
		|-> addr_q == tbl_addr(c.tbl_base, ch_q, alt_q[ch_q], `CTL_OFS))
		else $error("write-back aimed away from the control word");
	AST_PP_SWITCH: assert property (s_fin_wb ##0 (mode == `MODE_PINGPONG) // R19
		|=> irq_q[$past(ch_q)] && (alt_q ^ $past(alt_q)) == (32'h1 << $past(ch_q)))
		else $error("ping-pong switch without event or toggle");
	AST_DONE_DIS: assert property (s_fin_wb ##0 (mode != `MODE_PINGPONG) // R14
		|=> hwdis_q[$past(ch_q)] && irq_q[$past(ch_q)])
		else $error("finished channel not disabled");
endmodule : dma_channel_ctrl
`default_nettype wire

//--- rtl/dma_regs.sv
// APB slave holding channel enable, burst-only and table base registers
// Assumes an APB master on pclk; one wait state on every access
`timescale 1ns/1ps
`default_nettype none
`include "dma_defs.svh"
module dma_regs (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Engine side
	ctl_if.regs c
);
	logic [31:0] en_q, en_d, bo_q, bo_d, prdata_q, prdata_d;
	logic [21:0] base_q, base_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic acc, commit;

	// ======================================================================
	// Access decode
	// Write lands at the edge where pready is seen high
	assign acc = psel & penable & ~pready_q;
	assign commit = psel & penable & pready_q & pwrite & ~pslverr_q;

	// Next register values; hardware clear applied first so a set wins
	always_comb begin
		en_d = en_q & ~c.hw_dis; // R14
		bo_d = bo_q;
		base_d = base_q;
		pready_d = acc;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		if (acc) begin
			case (paddr)
			`REG_ENA_SET, `REG_ENA_CLR: prdata_d = en_q;
			`REG_BO_SET, `REG_BO_CLR: prdata_d = bo_q;
			`REG_TBL_BASE: prdata_d = {base_q, 10'h000};
			`REG_STATUS: prdata_d = {26'h0, c.cur_chan, c.busy};
			default: begin
				prdata_d = 32'h0;
				pslverr_d = 1'b1;
			end
			endcase
		end
		if (commit) begin
			case (paddr)
			`REG_ENA_SET: en_d = en_d | pwdata; // R13
			`REG_ENA_CLR: en_d = en_d & ~pwdata; // R13
			`REG_BO_SET: bo_d = bo_q | pwdata; // R4
			`REG_BO_CLR: bo_d = bo_q & ~pwdata;
			`REG_TBL_BASE: base_d = pwdata[31:`TBL_LSB]; // R5
			default: begin
			end
			endcase
		end
	end

	// Register stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= `EN_RST;
			bo_q <= `BO_RST;
			base_q <= `BASE_RST;
			pready_q <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			en_q <= en_d;
			bo_q <= bo_d;
			base_q <= base_d;
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign c.en = en_q;
	assign c.burst_only = bo_q;
	assign c.tbl_base = base_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_EN_SET: assert property (commit && paddr == `REG_ENA_SET // R13
		|=> (en_q & $past(pwdata)) == $past(pwdata))
		else $error("enable set write lost");
	AST_EN_CLR: assert property (commit && paddr == `REG_ENA_CLR // R13
		|=> (en_q & $past(pwdata)) == 32'h0)
		else $error("enable clear write lost");
	AST_HW_CLR: assert property (c.hw_dis != 32'h0 && !(commit && paddr == `REG_ENA_SET) // R14
		|=> (en_q & $past(c.hw_dis)) == 32'h0)
		else $error("hardware disable did not clear enable");
	AST_BO_SET: assert property (commit && paddr == `REG_BO_SET // R4
		|=> (bo_q & $past(pwdata)) == $past(pwdata))
		else $error("burst-only set write lost");
endmodule : dma_regs
`default_nettype wire

//--- rtl/dma_req_sync.sv
// Three-stage synchronisers for the peripheral request pins
// Assumes raw requests are asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "dma_defs.svh"
module dma_req_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Raw pins in, settled levels out
	input wire logic [2*`NCH-1:0] raw,
	output logic [2*`NCH-1:0] sync
);
	logic [2*`NCH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

	// ======================================================================
	// Agreement filter
	// A new level counts only once stages two and three agree
	for (genvar i = 0; i < 2*`NCH; i++) begin : g_bit
		assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
	end

	// Stage registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end
	assign sync = lvl_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SYNC_HOLD: assert property ((s2_q != s3_q) && (lvl_q == s3_q) |=> lvl_q == $past(lvl_q))
		else $error("request level moved while stages disagree"); // R1
endmodule : dma_req_sync
`default_nettype wire

//--- sim/dma_mem_model.sv
// System memory seen by the DMA engine: word store with a settable answer delay
// Assumes held requests and word items; mem_size is not used to mask lanes
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Wait cycles before each answer
	input wire logic [3:0] dly,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [31:0] mem [logic [31:0]];
	logic [3:0] wait_q;
	// ==========================================================
	// Answer one held request; read data is scrambled off the ack cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			wait_q <= 4'h0;
			mem_rdata <= 32'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack) begin
				if (wait_q >= dly) begin
					mem_ack <= 1'b1;
					wait_q <= 4'h0;
					if (mem_we) begin
						mem[mem_addr] = mem_wdata;
					end else begin
						mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
					end
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule : dma_mem_model
`default_nettype wire

//--- sim/dma_request_and_channel_control_bench.sv
// Self-checking bench: APB set-up, peripheral requests, memory-side results
// Assumes dma_mem_model as system memory and word items throughout
`timescale 1ns/1ps
`default_nettype none
`include "dma_defs.svh"
module dma_request_and_channel_control_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, sreq = 32'h0, breq = 32'h0, mem_addr, mem_wdata, mem_rdata, chan_irq;
	logic pready, pslverr, mem_req, mem_we, mem_ack;
	logic [1:0] mem_size;
	logic [3:0] dly = 4'h0;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int irq_n [32];
	localparam logic [31:0] TBL = 32'h0000_4000; // 1024-byte aligned base
	// ==========================================================
	// Design, memory and clock
	dma_channel_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .single_req(sreq), .burst_req(breq), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .chan_irq(chan_irq));
	dma_mem_model u_mem (.pclk(pclk), .presetn(presetn), .dly(dly), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	always #2.5 pclk = ~pclk;
	// Event pulses are one cycle wide, so count them per channel; cut hangs short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 32; i++) if (chan_irq[i] === 1'b1) irq_n[i] <= irq_n[i] + 1;
		if (cyc == 30000) begin
			n_errors = n_errors + 1;
			tally_and_finish();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x, "read data");
		chk({31'h0, e}, {31'h0, xe}, "slave error");
	endtask : rd
	function automatic logic [31:0] sa(input int ch, input logic alt);
		return TBL + 32'(ch * 16) + (alt ? `ALT_OFS : 32'h0);
	endfunction : sa
	// Destination is a fixed register, source increments by words
	function automatic logic [31:0] cw(input logic [2:0] m, input int n, input logic [3:0] arb);
		return {`INC_NONE, `WORD_SIZE, 2'h2, `WORD_SIZE, 6'h00, arb, 10'(n - 1), 1'b0, m};
	endfunction : cw
	task automatic set_chan(input int ch, input logic alt, input logic [31:0] src,
		input logic [31:0] dst, input logic [31:0] w, input int n);
		for (int i = 0; i < n; i++) u_mem.mem[src + 32'(4 * i)] = ~(src + 32'(4 * i));
		u_mem.mem[sa(ch, alt)] = src + 32'(4 * (n - 1)); // inclusive end
		u_mem.mem[sa(ch, alt) + 32'h4] = dst; // fixed end is the register
		u_mem.mem[sa(ch, alt) + 32'h8] = w; // fresh control word
		u_mem.mem[dst] = 32'h0;
	endtask : set_chan
	task automatic ctl(input int ch, input logic alt, input logic [9:0] n, input logic [2:0] m);
		logic [31:0] w;
		w = u_mem.mem[sa(ch, alt) + 32'h8];
		chk({19'h0, w[13:4], w[2:0]}, {19'h0, n, m}, "count and mode");
	endtask : ctl
	task automatic settle();
		int q;
		int k;
		q = 0;
		k = 0;
		while (q < 40 && k < 3000) begin
			@(posedge pclk);
			q = mem_req ? 0 : q + 1;
			k++;
		end
	endtask : settle
	task automatic pulse(input int ch, input logic s, input logic b);
		@(posedge pclk);
		sreq[ch] <= s;
		breq[ch] <= b;
		repeat (b ? 12 : 6) @(posedge pclk); // Burst held through one arbitration run
		sreq[ch] <= 1'b0;
		breq[ch] <= 1'b0;
		settle();
	endtask : pulse
	task automatic wait_irq(input int ch, input int n);
		int k;
		k = 0;
		while (irq_n[ch] < n && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		chk(32'(irq_n[ch]), 32'(n), "event count");
	endtask : wait_irq
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rd(`REG_ENA_SET, 32'h0, 1'b0);
		rd(`REG_BO_SET, 32'h0, 1'b0);
		wr(`REG_TBL_BASE, TBL);
		rd(`REG_TBL_BASE, TBL, 1'b0);
		wr(`REG_ENA_SET, 32'h0000_0a00);
		rd(`REG_ENA_CLR, 32'h0000_0a00, 1'b0);
		wr(`REG_ENA_CLR, 32'h0000_0800);
		rd(`REG_ENA_SET, 32'h0000_0200, 1'b0);
		wr(`REG_ENA_CLR, 32'h0000_0200);
		rd(12'h020, 32'h0, 1'b1);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_basic();
		set_chan(3, 1'b0, 32'h1000, 32'h3000, cw(`MODE_BASIC, 4, 4'h1), 4);
		wr(`REG_ENA_SET, 32'h0000_0008);
		pulse(3, 1'b1, 1'b0);
		chk(u_mem.mem[32'h3000], ~32'h1000, "single item");
		ctl(3, 1'b0, 10'h2, `MODE_BASIC);
		pulse(3, 1'b1, 1'b1);
		chk(u_mem.mem[32'h3000], ~32'h1008, "burst of two");
		ctl(3, 1'b0, 10'h0, `MODE_BASIC);
		pulse(3, 1'b0, 1'b1);
		chk(u_mem.mem[32'h3000], ~32'h100c, "last item");
		ctl(3, 1'b0, 10'h0, `MODE_STOP);
		chk(u_mem.mem[sa(3, 1'b0)], 32'h100c, "source end");
		chk(u_mem.mem[sa(3, 1'b0) + 32'h4], 32'h3000, "destination end");
		chk(32'(irq_n[3]), 32'h1, "completion event");
		rd(`REG_ENA_SET, 32'h0, 1'b0);
		rd(`REG_STATUS, 32'h0000_0006, 1'b0);
		$display("t_basic done");
	endtask : t_basic
	task automatic t_bonly();
		set_chan(5, 1'b0, 32'h1500, 32'h3014, cw(`MODE_BASIC, 2, 4'h0), 2);
		wr(`REG_BO_SET, 32'h0000_0020);
		wr(`REG_ENA_SET, 32'h0000_0020);
		pulse(5, 1'b1, 1'b0);
		ctl(5, 1'b0, 10'h1, `MODE_BASIC);
		pulse(5, 1'b0, 1'b1);
		ctl(5, 1'b0, 10'h0, `MODE_BASIC);
		wr(`REG_BO_CLR, 32'h0000_0020);
		wr(`REG_ENA_CLR, 32'h0000_0020);
		$display("t_bonly done");
	endtask : t_bonly
	task automatic t_auto();
		dly <= 4'h3;
		set_chan(7, 1'b0, 32'h1700, 32'h301c, cw(`MODE_AUTO, 5, 4'h0), 5);
		wr(`REG_ENA_SET, 32'h0000_0080);
		pulse(7, 1'b1, 1'b0);
		wait_irq(7, 1);
		settle();
		chk(u_mem.mem[32'h301c], ~32'h1710, "auto last item");
		ctl(7, 1'b0, 10'h0, `MODE_STOP);
		rd(`REG_ENA_SET, 32'h0, 1'b0);
		dly <= 4'h0;
		$display("t_auto done");
	endtask : t_auto
	task automatic t_idle();
		set_chan(9, 1'b0, 32'h1900, 32'h3024, cw(`MODE_STOP, 2, 4'h0), 2);
		set_chan(11, 1'b0, 32'h1b00, 32'h302c, cw(`MODE_BASIC, 2, 4'h0), 2);
		wr(`REG_ENA_SET, 32'h0000_0200);
		pulse(9, 1'b1, 1'b0);
		pulse(11, 1'b1, 1'b0);
		chk(u_mem.mem[32'h3024], 32'h0, "stop moved data");
		rd(`REG_ENA_SET, 32'h0, 1'b0);
		chk(u_mem.mem[32'h302c], 32'h0, "disabled moved data");
		ctl(11, 1'b0, 10'h1, `MODE_BASIC);
		$display("t_idle done");
	endtask : t_idle
	task automatic t_pingpong();
		set_chan(2, 1'b0, 32'h1200, 32'h3008, cw(`MODE_PINGPONG, 2, 4'h0), 2);
		set_chan(2, 1'b1, 32'h1280, 32'h3008, cw(`MODE_PINGPONG, 2, 4'h0), 2);
		wr(`REG_ENA_SET, 32'h0000_0004);
		sreq[2] <= 1'b1;
		wait_irq(2, 1);
		chk(u_mem.mem[32'h3008], ~32'h1204, "primary done");
		ctl(2, 1'b0, 10'h0, `MODE_STOP);
		set_chan(2, 1'b0, 32'h1200, 32'h3008, cw(`MODE_PINGPONG, 2, 4'h0), 2);
		wait_irq(2, 2);
		chk(u_mem.mem[32'h3008], ~32'h1284, "alternate done");
		sreq[2] <= 1'b0;
		settle();
		ctl(2, 1'b1, 10'h0, `MODE_STOP);
		rd(`REG_ENA_SET, 32'h0000_0004, 1'b0);
		$display("t_pingpong done");
	endtask : t_pingpong
	// ==========================================================
	// Verdict
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_basic();
		t_bonly();
		t_auto();
		t_idle();
		t_pingpong();
		tally_and_finish();
	end
endmodule : dma_request_and_channel_control_bench
`default_nettype wire
